// ==== logic/port_cfg.svh ====
// constants for the port pin block: offsets, field positions, reset values
`ifndef PORT_CFG_SVH
`define PORT_CFG_SVH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define NPORTS 10
`define NPINS 80
`define NEXT_IRQ 7

// ----------------------------------------------------------------
// register offsets (byte addresses on the plain register port)
// ----------------------------------------------------------------
`define OFS_DATA 8'h00
`define OFS_MODE 8'h10
`define OFS_PULL 8'h20
`define OFS_RISE 8'h30
`define OFS_FALL 8'h31
`define OFS_STAT 8'h32
`define OFS_MASK 8'h33
`define OFS_CTRL 8'h34
`define OFS_CPUCLK 8'h35
`define PORT_CNT 8'h0a

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define STAT_KEY_BIT 7
`define CTRL_ANALOG_BIT 0
`define CTRL_EXTMEM_BIT 1
`define CPUCLK_FB_OFF_BIT 6
`define MODE_RST 8'hff
`define CPUCLK_RST 8'h00

// ----------------------------------------------------------------
// port index and flat pin positions
// ----------------------------------------------------------------
`define PIDX_P0 0
`define PIDX_P1 1
`define PIDX_P4 4
`define PIDX_P6 6
`define PIDX_P7 7
`define PIDX_P13 9
`define P4_LSB 32
`define P5_LSB 40
`define PIN_RD 52
`define PIN_WR 53
`define PIN_WAIT 54
`define PIN_ADDR_LATCH 55

`endif

// ==== logic/port_pkg.sv ====
// types shared by the port pin block
`include "port_cfg.svh"

package port_pkg;

	// external memory bus cycle phases
	typedef enum logic [3:0] {
		BUS_IDLE = 4'b0001,
		BUS_ADDR = 4'b0010,
		BUS_STRB = 4'b0100,
		BUS_DONE = 4'b1000
	} bus_state_t;

	// whole block state, registered as one word
	typedef struct packed {
		logic [`NPORTS-1:0][7:0] latch;
		logic [`NPORTS-1:0][7:0] mode;
		logic [`NPORTS-1:0][7:0] pu;
		logic [`NEXT_IRQ-1:0] rise;
		logic [`NEXT_IRQ-1:0] fall;
		logic [7:0] stat;
		logic [7:0] mask;
		logic [1:0] ctrl;
		logic [7:0] cpuclk;
		logic [`NPINS-1:0] prev;
		bus_state_t bst;
		logic [15:0] addr;
		logic we;
		logic [7:0] wdata;
		logic [7:0] erd;
		logic [`NPINS-1:0] drv;
		logic [`NPINS-1:0] oe;
		logic [`NPINS-1:0] pull;
		logic [7:0] rdata;
		logic irq;
		logic done;
	} state_t;

endpackage

// ==== logic/mcu_port_pin_logic.sv ====
// general-purpose port pins, key-return flag, external irq edges, external bus
//
// Summary of operation
// - ports 1,2,3,5,7,12,13, P01-P06 per-bit direction
// - pull-up only acts while pin is input
// - port 4 falling edge sets key flag
// - analog port 1 pins lose their pull-ups
// - P60-P63 open drain, no pull-up
// - seven irq pins: rising, falling or both
// - ext bus: port 4 addr/data, port 5 high
// - port 7 three bits, port 13 two
// - wait stretches access; separate read/write strobes
`timescale 1ns/1ps
`default_nettype none
`include "port_cfg.svh"

module mcu_port_pin_logic (
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	input wire logic [`NPINS-1:0] pin_level_in,
	output logic [`NPINS-1:0] pin_drive_out,
	output logic [`NPINS-1:0] pin_oe_out,
	output logic [`NPINS-1:0] pin_pullup_out,
	input wire logic ext_req_in,
	input wire logic ext_we_in,
	input wire logic [15:0] ext_addr_in,
	input wire logic [7:0] ext_wdata_in,
	output logic [7:0] ext_rdata_out,
	output logic ext_done_out,
	output logic irq_out,
	output logic subclock_feedback_off_out
);
	import port_pkg::*;

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------

	// bits that exist on a port
	function automatic logic [7:0] width_mask(input int k);
		if (k == `PIDX_P7) begin
			return 8'h07;
		end else if (k == `PIDX_P13) begin
			return 8'h03;
		end
		return 8'hff;
	endfunction

	// bits whose direction software may turn to output
	function automatic logic [7:0] dir_mask(input int k);
		if (k == `PIDX_P0) begin
			return 8'h7e;
		end
		return width_mask(k);
	endfunction

	// bits that carry a software pull-up
	function automatic logic [7:0] pull_mask(input int k);
		if (k == `PIDX_P6) begin
			return 8'hf0;
		end
		return dir_mask(k);
	endfunction

	// output-mode bits from a mode byte (mode bit 1 = input)
	function automatic logic [7:0] out_bits(input int k, input logic [7:0] m);
		if (k == `PIDX_P4) begin
			return {8{~m[0]}};
		end
		return ~m & dir_mask(k);
	endfunction

	// address hits a per-port bank; index is the port slot
	function automatic logic bank_hit(input logic [7:0] a, input logic [7:0] base);
		return (a >= base) && (a < base + `PORT_CNT);
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	state_t s_q;
	state_t s_d;
	logic [7:0] ofs;
	logic [3:0] idx;
	logic [`NEXT_IRQ-1:0] irq_ev;
	logic key_ev;
	logic [7:0] om;
	logic ext_en;

	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------

	// register access, edge events, bus cycle, then pin drive
	always_comb begin
		s_d = s_q;
		s_d.rdata = 8'h00;
		s_d.done = 1'b0;
		s_d.prev = pin_level_in;
		ofs = 8'h00;
		idx = 4'h0;
		om = 8'h00;
		ext_en = s_q.ctrl[`CTRL_EXTMEM_BIT];

		irq_ev = (s_q.rise & pin_level_in[`NEXT_IRQ-1:0] & ~s_q.prev[`NEXT_IRQ-1:0])
			| (s_q.fall & ~pin_level_in[`NEXT_IRQ-1:0] & s_q.prev[`NEXT_IRQ-1:0]);
		key_ev = |(s_q.prev[`P4_LSB+7:`P4_LSB] & ~pin_level_in[`P4_LSB+7:`P4_LSB]);

		// register writes; stat bits clear by writing one
		if (reg_wr_in) begin
			if (bank_hit(reg_addr_in, `OFS_DATA)) begin
				ofs = reg_addr_in - `OFS_DATA;
				idx = ofs[3:0];
				s_d.latch[idx] = reg_wdata_in & width_mask(int'(idx));
			end else if (bank_hit(reg_addr_in, `OFS_MODE)) begin
				ofs = reg_addr_in - `OFS_MODE;
				idx = ofs[3:0];
				s_d.mode[idx] = reg_wdata_in | ~width_mask(int'(idx));
			end else if (bank_hit(reg_addr_in, `OFS_PULL)) begin
				ofs = reg_addr_in - `OFS_PULL;
				idx = ofs[3:0];
				s_d.pu[idx] = reg_wdata_in & pull_mask(int'(idx));
			end else begin
				unique case (reg_addr_in)
					`OFS_RISE: s_d.rise = reg_wdata_in[`NEXT_IRQ-1:0];
					`OFS_FALL: s_d.fall = reg_wdata_in[`NEXT_IRQ-1:0];
					`OFS_STAT: s_d.stat = s_q.stat & ~reg_wdata_in;
					`OFS_MASK: s_d.mask = reg_wdata_in;
					`OFS_CTRL: s_d.ctrl = reg_wdata_in[1:0];
					`OFS_CPUCLK: s_d.cpuclk = reg_wdata_in;
					default: s_d.ctrl = s_q.ctrl;
				endcase
			end
		end

		// set after clear so an event in the clearing cycle survives
		// key flag on bit 7, irq pins on bits 6..0: exactly eight bits
		s_d.stat = s_d.stat | {key_ev, irq_ev};

		// register reads, data stands the following cycle only
		if (reg_rd_in) begin
			if (bank_hit(reg_addr_in, `OFS_DATA)) begin
				ofs = reg_addr_in - `OFS_DATA;
				idx = ofs[3:0];
				om = out_bits(int'(idx), s_q.mode[idx]);
				// latch for outputs, pin for inputs
				s_d.rdata = ((s_q.latch[idx] & om) | (pin_level_in[idx*8 +: 8] & ~om))
					& width_mask(int'(idx));
			end else if (bank_hit(reg_addr_in, `OFS_MODE)) begin
				ofs = reg_addr_in - `OFS_MODE;
				idx = ofs[3:0];
				s_d.rdata = s_q.mode[idx];
			end else if (bank_hit(reg_addr_in, `OFS_PULL)) begin
				ofs = reg_addr_in - `OFS_PULL;
				idx = ofs[3:0];
				s_d.rdata = s_q.pu[idx];
			end else begin
				unique case (reg_addr_in)
					`OFS_RISE: s_d.rdata = {1'b0, s_q.rise};
					`OFS_FALL: s_d.rdata = {1'b0, s_q.fall};
					`OFS_STAT: s_d.rdata = s_q.stat;
					`OFS_MASK: s_d.rdata = s_q.mask;
					`OFS_CTRL: s_d.rdata = {6'h00, s_q.ctrl};
					`OFS_CPUCLK: s_d.rdata = s_q.cpuclk;
					default: s_d.rdata = 8'h00;
				endcase
			end
		end

		// external access phases; low wait pin holds the strobe
		unique case (s_q.bst)
			BUS_IDLE: begin
				if (ext_en && ext_req_in) begin
					s_d.addr = ext_addr_in;
					s_d.we = ext_we_in;
					s_d.wdata = ext_wdata_in;
					s_d.bst = BUS_ADDR;
				end
			end
			BUS_ADDR: s_d.bst = BUS_STRB;
			BUS_STRB: begin
				if (pin_level_in[`PIN_WAIT]) begin
					s_d.erd = pin_level_in[`P4_LSB+7:`P4_LSB];
					s_d.bst = BUS_DONE;
				end
			end
			BUS_DONE: s_d.bst = BUS_IDLE;
		endcase
		s_d.done = (s_d.bst == BUS_DONE);

		// synchronous reset: every port input, no pull-ups, bus idle
		if (sys_rst_in) begin
			s_d = '0;
			s_d.mode = {`NPORTS{`MODE_RST}};
			s_d.cpuclk = `CPUCLK_RST;
			s_d.bst = BUS_IDLE;
			s_d.prev = pin_level_in;
		end

		// pin drive from the next register values, so pins change on the same edge that takes a write
		for (int k = 0; k < `NPORTS; k++) begin
			om = out_bits(k, s_d.mode[k]);
			s_d.oe[k*8 +: 8] = om;
			s_d.drv[k*8 +: 8] = s_d.latch[k] & om;
			s_d.pull[k*8 +: 8] = s_d.pu[k] & ~om & pull_mask(k);
		end
		// open-drain bits only ever pull low
		s_d.oe[51:48] = s_d.oe[51:48] & ~s_d.latch[`PIDX_P6][3:0];
		s_d.drv[51:48] = 4'h0;
		if (s_d.ctrl[`CTRL_ANALOG_BIT]) begin
			s_d.pull[15:8] = 8'h00;
		end

		// external bus owns ports 4, 5 and the strobe pins
		if (s_d.ctrl[`CTRL_EXTMEM_BIT]) begin
			s_d.oe[`P4_LSB+7:`P4_LSB] = {8{(s_d.bst == BUS_ADDR) || (s_d.bst == BUS_STRB && s_d.we)}};
			s_d.drv[`P4_LSB+7:`P4_LSB] = (s_d.bst == BUS_ADDR) ? s_d.addr[7:0] :
				((s_d.bst == BUS_STRB && s_d.we) ? s_d.wdata : 8'h00);
			s_d.oe[`P5_LSB+7:`P5_LSB] = 8'hff;
			s_d.drv[`P5_LSB+7:`P5_LSB] = s_d.addr[15:8];
			s_d.oe[`PIN_ADDR_LATCH:`PIN_RD] = 4'b1011;
			s_d.drv[`PIN_RD] = !(s_d.bst == BUS_STRB && !s_d.we);
			s_d.drv[`PIN_WR] = !(s_d.bst == BUS_STRB && s_d.we);
			s_d.drv[`PIN_WAIT] = 1'b0;
			s_d.drv[`PIN_ADDR_LATCH] = (s_d.bst == BUS_ADDR);
			s_d.pull[`P5_LSB+7:`P4_LSB] = 16'h0000;
			s_d.pull[`PIN_ADDR_LATCH:`PIN_RD] = 4'h0;
		end

		// level interrupt from unmasked sticky bits
		s_d.irq = |(s_d.stat & s_d.mask);
	end

	// single state register
	always_ff @(posedge ref_clk_in) begin
		s_q <= s_d;
	end

	// ----------------------------------------------------------------
	// outputs, all straight from the state register
	// ----------------------------------------------------------------
	assign reg_rdata_out = s_q.rdata;
	assign pin_drive_out = s_q.drv;
	assign pin_oe_out = s_q.oe;
	assign pin_pullup_out = s_q.pull;
	assign ext_rdata_out = s_q.erd;
	assign ext_done_out = s_q.done;
	assign irq_out = s_q.irq;
	// feedback-off bit handed to the subclock oscillator
	assign subclock_feedback_off_out = s_q.cpuclk[`CPUCLK_FB_OFF_BIT];

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (sys_rst_in);

	a_input_only_bits: assert property ((pin_oe_out[0] == 1'b0) && (pin_oe_out[7] == 1'b0))
		else $error("input-only port 0 bit driven");
	a_p4_common_dir: assert property (!s_q.ctrl[`CTRL_EXTMEM_BIT] |->
		(pin_oe_out[39:32] == 8'h00) || (pin_oe_out[39:32] == 8'hff))
		else $error("port 4 bits disagree on direction");
	a_pullup_input_only: assert property ((pin_pullup_out & pin_oe_out) == '0)
		else $error("pull-up on a driving pin");
	a_key_flag_set: assert property ((|(s_q.prev[39:32] & ~pin_level_in[39:32])) |=>
		s_q.stat[`STAT_KEY_BIT])
		else $error("key flag missed a port 4 falling edge");
	a_analog_no_pull: assert property (s_q.ctrl[`CTRL_ANALOG_BIT] |-> pin_pullup_out[15:8] == 8'h00)
		else $error("analog pin pulled up");
	a_open_drain_pins: assert property ((pin_drive_out[51:48] == 4'h0)
		&& (pin_pullup_out[51:48] == 4'h0))
		else $error("open-drain pin driven high or pulled up");
	a_rise_edge_irq: assert property ((s_q.rise[0] && !s_q.prev[0] && pin_level_in[0]) |=> s_q.stat[0])
		else $error("rising edge on irq pin 0 missed");
	a_addr_strobe: assert property ((s_q.bst == BUS_ADDR && s_q.ctrl[`CTRL_EXTMEM_BIT])
		|-> pin_drive_out[`PIN_ADDR_LATCH] && pin_drive_out[47:40] == s_q.addr[15:8]
		&& pin_drive_out[39:32] == s_q.addr[7:0])
		else $error("address phase output wrong");
	a_port_widths: assert property ((pin_oe_out[63:59] == 5'h00) && (pin_oe_out[79:74] == 6'h00))
		else $error("missing port 7 or 13 bit driven");
	a_wait_stretch: assert property ((s_q.bst == BUS_STRB && !pin_level_in[`PIN_WAIT])
		|=> s_q.bst == BUS_STRB ##1 (s_q.bst == BUS_STRB || s_q.bst == BUS_DONE))
		else $error("wait did not hold the strobe phase");
	// read and write strobes are separate and never active together
	a_strobe_apart: assert property (s_q.ctrl[`CTRL_EXTMEM_BIT] |->
		pin_drive_out[`PIN_RD] || pin_drive_out[`PIN_WR])
		else $error("read and write strobes low together");
	a_read_mux: assert property ((reg_rd_in && reg_addr_in == 8'h02) |=>
		reg_rdata_out == (($past(s_q.latch[2]) & ~$past(s_q.mode[2]))
		| ($past(pin_level_in[23:16]) & $past(s_q.mode[2]))))
		else $error("port 2 read returned wrong mix");

endmodule
`default_nettype wire

// ==== testbench/ext_board_model.sv ====
// board circuitry and external memory facing the port pins
`timescale 1ns/1ps
`default_nettype none
module ext_board_model (
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	input wire logic ext_mode_in,
	input wire logic [79:0] drive_in,
	input wire logic [79:0] oe_in,
	input wire logic [79:0] pullup_in,
	input wire logic [79:0] board_in,
	input wire logic [7:0] mem_byte_in,
	input wire logic [3:0] wait_len_in,
	output logic [79:0] level_out
);
	logic rd_low, strb_low;
	logic [3:0] wcnt_q;
	// strobes mean nothing until the bus mode is on, the pins are plain port bits then
	assign rd_low = ext_mode_in & oe_in[52] & ~drive_in[52];
	assign strb_low = rd_low | (ext_mode_in & oe_in[53] & ~drive_in[53]);
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in || !strb_low) begin
			wcnt_q <= 4'h0;
		end else if (wcnt_q != 4'hf) begin
			wcnt_q <= wcnt_q + 4'h1;
		end
	end
	// released pins follow pull-up or the ever-changing board
	always_comb begin
		level_out = (oe_in & drive_in) | (~oe_in & (pullup_in | board_in));
		if (strb_low) begin
			level_out[54] = !(wcnt_q < wait_len_in);
		end
		if (rd_low) begin
			level_out[39:32] = mem_byte_in;
		end
	end
endmodule
`default_nettype wire

// ==== testbench/mcu_port_pin_logic_tb_top.sv ====
// self-checking bench for the port pin block
`timescale 1ns/1ps
`default_nettype none
`include "port_cfg.svh"
module mcu_port_pin_logic_tb_top;
	logic clk = 1'h0, rst = 1'h1, wr = 1'h0, rd = 1'h0, req = 1'h0, we = 1'h0, xm = 1'h0;
	logic [7:0] ad = 8'h00, wd = 8'h00, xw = 8'h00, mb = 8'h00, rdat, xrd, v;
	logic [15:0] xa = 16'h0000, seed = 16'h1ec6;
	logic [3:0] wl = 4'h0;
	logic [79:0] brd = 80'h0, drv, oe, pu, lvl;
	logic [7:0] lat [10], mo [10], pl [10];
	logic done, irq, fb;
	int mismatches = 0, checks = 0, cyc = 0;
	mcu_port_pin_logic u_dut (
		.ref_clk_in(clk), .sys_rst_in(rst), .reg_addr_in(ad), .reg_wdata_in(wd),
		.reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat), .pin_level_in(lvl),
		.pin_drive_out(drv), .pin_oe_out(oe), .pin_pullup_out(pu), .ext_req_in(req),
		.ext_we_in(we), .ext_addr_in(xa), .ext_wdata_in(xw), .ext_rdata_out(xrd),
		.ext_done_out(done), .irq_out(irq), .subclock_feedback_off_out(fb));
	ext_board_model u_board (
		.ref_clk_in(clk), .sys_rst_in(rst), .ext_mode_in(xm), .drive_in(drv), .oe_in(oe),
		.pullup_in(pu), .board_in(brd), .mem_byte_in(mb), .wait_len_in(wl), .level_out(lvl));
	// 40 MHz clock
	initial begin
		forever #12.5 clk = ~clk;
	end
	// hang guard, a few times the expected run
	always @(posedge clk) begin
		cyc++;
		if (cyc == 6000) begin
			mismatches++;
			report_and_stop();
		end
	end
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] rnd();
		seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
		return seed[7:0];
	endfunction
	task automatic chk(input string n, input logic [79:0] s, input logic [79:0] e);
		checks++;
		if (s !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic rw(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		ad <= a;
		wd <= d;
		wr <= 1'h1;
		@(posedge clk);
		wr <= 1'h0;
	endtask
	task automatic rr(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		ad <= a;
		rd <= 1'h1;
		@(posedge clk);
		rd <= 1'h0;
		#1 d = rdat;
	endtask
	// expectation of one slot from the bench's own copy of its registers
	task automatic slot_chk(input int k);
		logic [7:0] pr, o, p, e;
		pr = (k == 7) ? 8'h07 : (k == 9) ? 8'h03 : 8'hff;
		o = ~((k == 4) ? {8{mo[4][0]}} : mo[k]) & pr & ((k == 0) ? 8'h7e : 8'hff);
		p = pl[k] & ~o & pr & ((k == 6) ? 8'hf0 : 8'hff);
		e = (k == 6) ? (o & ~(lat[k] & 8'h0f)) : o;
		chk("oe", oe[k*8+:8], e);
		chk("pullup", pu[k*8+:8], p);
		chk("drive", drv[k*8+:8] & e, lat[k] & e);
		rr(`OFS_DATA + 8'(k), v);
		chk("read", v, ((lat[k] & o) | ((brd[k*8+:8] | p) & ~o)) & pr);
	endtask
	// clear status, move eight board pins, read the status bits that moved
	task automatic hit(input int lo, input logic [7:0] to, input logic [7:0] m, input logic [7:0] e);
		rw(`OFS_STAT, 8'hff);
		brd[lo+:8] <= to;
		repeat (3) @(posedge clk);
		rr(`OFS_STAT, v);
		chk("status", v & m, e);
	endtask
	task automatic ext(input logic w, input logic [15:0] a, input logic [7:0] d, input int n);
		int c, s, t;
		logic [7:0] m;
		m = rnd();
		c = 0;
		s = 0;
		t = 0;
		@(posedge clk);
		{mb, wl, we, xa, xw, req} <= {m, 4'(n), w, a, d, 1'h1};
		do begin
			@(posedge clk);
			#1 c++;
			if (oe[`PIN_ADDR_LATCH] && drv[`PIN_ADDR_LATCH]) begin
				t++;
				chk("address", {drv[47:40], drv[39:32]}, a);
			end
			if (oe[w ? `PIN_WR : `PIN_RD] && !drv[w ? `PIN_WR : `PIN_RD]) begin
				s++;
				if (w) chk("write data", drv[39:32], d);
			end
		end while (!done && c < 20);
		chk("latency", c, 3 + n);
		chk("strobe cycles", s, 1 + n);
		chk("address strobes", t, 1);
		if (!w) chk("read data", xrd, m);
		@(posedge clk);
		req <= 1'h0;
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		// reset is held by the outside party for the first cycles
		repeat (16) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		#1 chk("oe after reset", oe, 80'h0);
		chk("pullup after reset", pu, 80'h0);
		for (int k = 0; k < 10; k++) begin
			rr(`OFS_MODE + 8'(k), v);
			chk("mode reset", v, `MODE_RST);
		end
		rr(8'h40, v);
		chk("unmapped", v, 8'h00);
		rw(`OFS_CPUCLK, 8'h40);
		#1 chk("feedback off", fb, 1'h1);
		// first pass is a hand-made corner: all outputs, open-drain bits released
		for (int n = 0; n < 12; n++) begin
			for (int k = 0; k < 10; k++) begin
				lat[k] = (n == 0) ? 8'h0f : rnd();
				mo[k] = (n == 0) ? 8'h00 : rnd();
				pl[k] = rnd() & ((k == 0) ? 8'h7e : 8'hff);
				rw(`OFS_DATA + 8'(k), lat[k]);
				rw(`OFS_MODE + 8'(k), mo[k]);
				rw(`OFS_PULL + 8'(k), pl[k]);
				brd[k*8+:8] <= rnd();
			end
			@(posedge clk);
			#1 for (int k = 0; k < 10; k++) slot_chk(k);
		end
		// analog use strips port 1 pull-ups
		rw(`OFS_CTRL, 8'h01);
		rw(`OFS_MODE + 8'h01, 8'hff);
		rw(`OFS_PULL + 8'h01, 8'hff);
		#1 chk("analog pullup", pu[15:8], 8'h00);
		rw(`OFS_CTRL, 8'h00);
		#1 chk("digital pullup", pu[15:8], 8'hff);
		// every edge selection on the seven irq pins
		rw(`OFS_MODE, 8'hff);
		rw(`OFS_PULL, 8'h00);
		brd[7:0] <= 8'h00;
		for (int md = 1; md < 4; md++) begin
			rw(`OFS_RISE, md[0] ? 8'h7f : 8'h00);
			rw(`OFS_FALL, md[1] ? 8'h7f : 8'h00);
			hit(0, 8'h7f, 8'h7f, md[0] ? 8'h7f : 8'h00);
			hit(0, 8'h00, 8'h7f, md[1] ? 8'h7f : 8'h00);
		end
		// only a falling port 4 edge raises the flag
		rw(`OFS_MODE + 8'h04, 8'hff);
		rw(`OFS_PULL + 8'h04, 8'h00);
		brd[39:32] <= 8'h00;
		rw(`OFS_MASK, 8'h00);
		hit(32, 8'hff, 8'h80, 8'h00);
		hit(32, 8'hef, 8'h80, 8'h80);
		chk("irq masked", irq, 1'h0);
		rw(`OFS_MASK, 8'h80);
		@(posedge clk);
		#1 chk("irq", irq, 1'h1);
		rw(`OFS_STAT, 8'h80);
		@(posedge clk);
		#1 chk("irq cleared", irq, 1'h0);
		// external bus, reads and writes with growing waits
		rw(`OFS_CTRL, 8'h02);
		xm <= 1'h1;
		for (int n = 0; n < 4; n++) ext(n[0], (n == 3) ? 16'hffff : {rnd(), rnd()}, rnd(), n);
		report_and_stop();
	end
endmodule
`default_nettype wire
